/* rtl/logger_mission_pkg.sv */
// Register map, field layout and carrier types of the mission control block
package logger_mission_pkg;

   // ****************************************************************
   // Register addresses
   // ****************************************************************
   localparam logic [15:0] ADDR_THR_LO     = 16'h0208;
   localparam logic [15:0] ADDR_THR_HI     = 16'h0209;
   localparam logic [15:0] ADDR_SENSOR_CTL = 16'h0210;
   localparam logic [15:0] ADDR_MISSION    = 16'h0213;
   localparam logic [15:0] ADDR_ALARMS     = 16'h0214;
   localparam logic [15:0] ADDR_GENERAL    = 16'h0215;
   localparam logic [15:0] ADDR_DELAY_0    = 16'h0216;
   localparam logic [15:0] ADDR_DELAY_1    = 16'h0217;
   localparam logic [15:0] ADDR_DELAY_2    = 16'h0218;
   localparam logic [15:0] ADDR_STAMP_0    = 16'h0219;
   localparam logic [15:0] ADDR_STAMP_1    = 16'h021a;
   localparam logic [15:0] ADDR_STAMP_2    = 16'h021b;
   localparam logic [15:0] ADDR_STAMP_3    = 16'h021c;

   // ****************************************************************
   // Field positions and fixed bits
   // ****************************************************************
   localparam int MC_LOGGING_ENABLE = 0;
   localparam int MC_FORMAT_SELECT  = 2;
   localparam int MC_ALARM_START    = 5;
   localparam logic [7:0] MC_FIXED_ONES  = 8'hd0;
   localparam logic [7:0] MC_WRITE_MASK  = 8'h2d;
   localparam logic [7:0] MC_RESET       = 8'hd0;
   localparam int SC_LOW_ENABLE  = 0;
   localparam int SC_HIGH_ENABLE = 1;
   localparam logic [7:0] SC_WRITE_MASK  = 8'h03;
   localparam int AF_LOW   = 0;
   localparam int AF_HIGH  = 1;
   localparam int AF_RESET = 7;
   localparam logic [7:0] AF_FIXED_ONES  = 8'h70;
   localparam int GS_RUNNING  = 1;
   localparam int GS_CLEARED  = 3;
   localparam int GS_WAITING  = 4;
   localparam logic [7:0] GS_FIXED_ONES  = 8'hc0;
   localparam logic [7:0] GS_BACKUP_MASK = 8'h25;

   // ****************************************************************
   // Data-log and command constants
   // ****************************************************************
   localparam int LOG_AW = 24;
   localparam logic [LOG_AW-1:0] LOG_BASE = 24'h001000;
   localparam logic [7:0] WIPE_PARAM     = 8'h01;
   localparam logic [23:0] DELAY_ONE     = 24'h000001;

   typedef enum logic [1:0] {
      S_IDLE,
      S_DELAY,
      S_WAIT_ALARM,
      S_LOGGING
   } mission_state_e;

   // One temperature conversion result from the sensor
   typedef struct packed {
      logic [15:0] data;
      logic        valid;
      logic        forced;
   } conv_s;

   // One byte write into the data-log memory
   typedef struct packed {
      logic              we;
      logic [LOG_AW-1:0] addr;
      logic [7:0]        data;
   } log_write_s;

endpackage

/* rtl/logger_mission_control_status.sv */
// Mission control, start delay, alarm flags and status of the logger
// What this block does
// - Alarm-start off: mission begins at once or after delay, no alarm wait.
// - Alarm-start on: 8-bit conversions each interval, log only after alarm.
// - Triggering alarm reading is first stored sample, sample count not bumped.
// - Format bit 0 stores one byte per reading, 1 stores two bytes.
// - Two-byte format puts high byte at lower address, low byte next.
// - First logged value goes to address 1000h, then ascending addresses.
// - Alarm status read-only, bits 6:4 read one, bits 3:2 read zero.
// - Reset alarm always enabled, bit 7 set on power-on or battery fail.
// - Memory wipe clears all alarm flags together.
// - High flag bit 1 set and held on enabled reading at or above high.
// - Low flag bit 0 set and held on enabled reading at or below low.
// - Forced conversion and initial trigger alarm may also set the flags.
// - Answer conditional search whenever any alarm is recorded.
// - General status read-only: running bit 1, cleared bit 3, waiting 4.
// - General status bits 0, 2, 5 read one only for a backup copy.
// - Start delay counted in minutes, then measure or begin alarm testing.
// - Start delay held as unsigned 24-bit count.
// - Nonzero delay with alarm-start expires fully before alarm testing.
// - Start delay registers ignore writes while a mission runs.
// - Mission start time captured into read-only timestamp register.
// - High alarms raised only while high alarm enable is one.
// - Waiting bit set on alarm-start mission start, cleared by the alarm.
// - Cleared bit set by wipe with parameter 01h, zeroed at mission start.
// - Running bit set during mission, returns to zero when it ends.
`timescale 1ns/1ns
module logger_mission_control_status #(
   parameter logic [23:0] LOG_LAST = 24'h01ffff
) (
   input  wire logic                        i_clk,
   input  wire logic                        i_reset_n,
   input  wire logic                        i_ce,
   input  wire logic [15:0]                 i_reg_addr,
   input  wire logic                        i_reg_wr,
   input  wire logic [7:0]                  i_reg_wdata,
   output logic      [7:0]                  o_reg_rdata,
   input  wire logic                        i_start_mission,
   input  wire logic                        i_stop_mission,
   input  wire logic                        i_memory_wipe_command,
   input  wire logic [7:0]                  i_wipe_param,
   input  wire logic                        i_power_fail,
   input  wire logic                        i_backup_copy,
   input  wire logic                        i_minute_tick,
   input  wire logic [31:0]                 i_rtc_seconds,
   input  wire logger_mission_pkg::conv_s   i_conv,
   output logger_mission_pkg::log_write_s   o_log,
   output logic                             o_count_inc,
   output logic                             o_search_alarm,
   output logic                             o_conv_8bit
);

   // ****************************************************************
   // Elaboration check
   // ****************************************************************
   if (LOG_LAST < logger_mission_pkg::LOG_BASE) begin : g_bad_last
      $error("LOG_LAST lies below the data-log base address");
   end

   // ****************************************************************
   // State
   // ****************************************************************
   logger_mission_pkg::mission_state_e state_r, state_nxt;
   logger_mission_pkg::log_write_s     log_r, log_nxt;
   logic [7:0]  mission_r, mission_nxt;
   logic [7:0]  sensor_r, sensor_nxt;
   logic [7:0]  thr_lo_r, thr_lo_nxt;
   logic [7:0]  thr_hi_r, thr_hi_nxt;
   logic [23:0] delay_r, delay_nxt;
   logic [23:0] delay_cnt_r, delay_cnt_nxt;
   logic [31:0] stamp_r, stamp_nxt;
   logic [7:0]  flags_r, flags_nxt;
   logic        running_r, running_nxt;
   logic        cleared_r, cleared_nxt;
   logic        waiting_r, waiting_nxt;
   logic        pend_r, pend_nxt;
   logic [7:0]  pend_byte_r, pend_byte_nxt;
   logic [23:0] addr_r, addr_nxt;
   logic        count_r, count_nxt;
   logic [7:0]  rdata_nxt;
   logic        hi_hit;
   logic        lo_hit;
   logic        start_ok;
   logic        two_byte;
   logic        alarm_armed;

   // Threshold compare on the high byte only
   function automatic logic at_or_above(input logic [7:0] v,
                                        input logic [7:0] t);
      return v >= t;
   endfunction

   function automatic logic at_or_below(input logic [7:0] v,
                                        input logic [7:0] t);
      return v <= t;
   endfunction

   // Alarm hits gated by their enables
   assign hi_hit = i_conv.valid &&
                   sensor_r[logger_mission_pkg::SC_HIGH_ENABLE] &&
                   at_or_above(i_conv.data[15:8], thr_hi_r);
   assign lo_hit = i_conv.valid &&
                   sensor_r[logger_mission_pkg::SC_LOW_ENABLE] &&
                   at_or_below(i_conv.data[15:8], thr_lo_r);
   assign two_byte = mission_r[logger_mission_pkg::MC_FORMAT_SELECT];
   // Start needs a cleared memory and logging enabled by the host
   assign start_ok = i_start_mission && !running_r && cleared_r &&
                     mission_r[logger_mission_pkg::MC_LOGGING_ENABLE];
   // No alarm testing while the start delay still counts down
   assign alarm_armed = running_r &&
                        state_r != logger_mission_pkg::S_DELAY;

   // ****************************************************************
   // Next-state logic of the mission
   // ****************************************************************
   always_comb begin
      state_nxt     = state_r;
      mission_nxt   = mission_r;
      sensor_nxt    = sensor_r;
      thr_lo_nxt    = thr_lo_r;
      thr_hi_nxt    = thr_hi_r;
      delay_nxt     = delay_r;
      delay_cnt_nxt = delay_cnt_r;
      stamp_nxt     = stamp_r;
      flags_nxt     = flags_r;
      running_nxt   = running_r;
      cleared_nxt   = cleared_r;
      waiting_nxt   = waiting_r;
      pend_nxt      = 1'b0;
      pend_byte_nxt = pend_byte_r;
      addr_nxt      = addr_r;
      count_nxt     = 1'b0;
      log_nxt       = '0;
      // Configuration writes, locked while a mission runs
      if (i_reg_wr && !running_r) begin
         case (i_reg_addr)
            logger_mission_pkg::ADDR_MISSION:
               mission_nxt = logger_mission_pkg::MC_FIXED_ONES |
                  (i_reg_wdata & logger_mission_pkg::MC_WRITE_MASK);
            logger_mission_pkg::ADDR_SENSOR_CTL:
               sensor_nxt = i_reg_wdata & logger_mission_pkg::SC_WRITE_MASK;
            logger_mission_pkg::ADDR_THR_LO: thr_lo_nxt = i_reg_wdata;
            logger_mission_pkg::ADDR_THR_HI: thr_hi_nxt = i_reg_wdata;
            logger_mission_pkg::ADDR_DELAY_0: delay_nxt[7:0] = i_reg_wdata;
            logger_mission_pkg::ADDR_DELAY_1: delay_nxt[15:8] = i_reg_wdata;
            logger_mission_pkg::ADDR_DELAY_2:
               delay_nxt[23:16] = i_reg_wdata;
            default: ;
         endcase
      end
      // Memory wipe clears every alarm flag at once
      if (i_memory_wipe_command && !running_r &&
          i_wipe_param == logger_mission_pkg::WIPE_PARAM) begin
         flags_nxt[logger_mission_pkg::AF_HIGH]  = 1'b0;
         flags_nxt[logger_mission_pkg::AF_LOW]   = 1'b0;
         flags_nxt[logger_mission_pkg::AF_RESET] = 1'b0;
         cleared_nxt = 1'b1;
      end
      // Mission start: timestamp, running, pick first phase
      if (start_ok) begin
         running_nxt   = 1'b1;
         cleared_nxt   = 1'b0;
         stamp_nxt     = i_rtc_seconds;
         addr_nxt      = logger_mission_pkg::LOG_BASE;
         delay_cnt_nxt = delay_r;
         waiting_nxt   = mission_r[logger_mission_pkg::MC_ALARM_START] |
                         waiting_r;
         if (delay_r != '0) begin
            state_nxt = logger_mission_pkg::S_DELAY;
         end else if (mission_r[logger_mission_pkg::MC_ALARM_START]) begin
            state_nxt = logger_mission_pkg::S_WAIT_ALARM;
         end else begin
            state_nxt = logger_mission_pkg::S_LOGGING;
         end
      end else if (i_stop_mission && running_r) begin
         running_nxt = 1'b0;
         state_nxt   = logger_mission_pkg::S_IDLE;
      end else begin
         case (state_r)
            logger_mission_pkg::S_DELAY: begin
               // Minute countdown, then measure or test for alarm
               if (i_minute_tick) begin
                  delay_cnt_nxt = delay_cnt_r - logger_mission_pkg::DELAY_ONE;
                  if (delay_cnt_r == logger_mission_pkg::DELAY_ONE) begin
                     state_nxt = mission_r[logger_mission_pkg::MC_ALARM_START]
                        ? logger_mission_pkg::S_WAIT_ALARM
                        : logger_mission_pkg::S_LOGGING;
                  end
               end
            end
            logger_mission_pkg::S_WAIT_ALARM: begin
               // Triggering reading logged first, counter untouched
               if (!i_conv.forced && (hi_hit || lo_hit)) begin
                  state_nxt    = logger_mission_pkg::S_LOGGING;
                  log_nxt.we   = addr_r <= LOG_LAST;
                  log_nxt.addr = addr_r;
                  log_nxt.data = i_conv.data[15:8];
                  addr_nxt     = addr_r + logger_mission_pkg::DELAY_ONE;
                  pend_nxt      = two_byte;
                  pend_byte_nxt = i_conv.data[7:0];
               end
            end
            logger_mission_pkg::S_LOGGING: begin
               if (pend_r) begin
                  // Low byte at the following address
                  log_nxt.we   = addr_r <= LOG_LAST;
                  log_nxt.addr = addr_r;
                  log_nxt.data = pend_byte_r;
                  addr_nxt     = addr_r + logger_mission_pkg::DELAY_ONE;
               end else if (i_conv.valid && !i_conv.forced) begin
                  log_nxt.we    = addr_r <= LOG_LAST;
                  log_nxt.addr  = addr_r;
                  log_nxt.data  = i_conv.data[15:8];
                  addr_nxt      = addr_r + logger_mission_pkg::DELAY_ONE;
                  pend_nxt      = two_byte;
                  pend_byte_nxt = i_conv.data[7:0];
                  count_nxt     = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // Alarm flags: sticky, setting wins over the wipe
      if ((alarm_armed || i_conv.forced) && hi_hit) begin
         flags_nxt[logger_mission_pkg::AF_HIGH] = 1'b1;
      end
      if ((alarm_armed || i_conv.forced) && lo_hit) begin
         flags_nxt[logger_mission_pkg::AF_LOW] = 1'b1;
      end
      if ((hi_hit || lo_hit) && !start_ok &&
          (i_conv.forced || state_r == logger_mission_pkg::S_WAIT_ALARM)) begin
         waiting_nxt = 1'b0;
      end
      if (i_power_fail) begin
         flags_nxt[logger_mission_pkg::AF_RESET] = 1'b1;
      end
   end

   // Register the mission state
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r     <= logger_mission_pkg::S_IDLE;
         log_r       <= '0;
         mission_r   <= logger_mission_pkg::MC_RESET;
         sensor_r    <= 8'h00;
         thr_lo_r    <= 8'h00;
         thr_hi_r    <= 8'h00;
         delay_r     <= 24'h000000;
         delay_cnt_r <= 24'h000000;
         stamp_r     <= 32'h00000000;
         flags_r     <= 8'h80; // Reset alarm raised at power-on
         running_r   <= 1'b0;
         cleared_r   <= 1'b0;
         waiting_r   <= 1'b0;
         pend_r      <= 1'b0;
         pend_byte_r <= 8'h00;
         addr_r      <= logger_mission_pkg::LOG_BASE;
         count_r     <= 1'b0;
      end else if (i_ce) begin
         state_r     <= state_nxt;
         log_r       <= log_nxt;
         mission_r   <= mission_nxt;
         sensor_r    <= sensor_nxt;
         thr_lo_r    <= thr_lo_nxt;
         thr_hi_r    <= thr_hi_nxt;
         delay_r     <= delay_nxt;
         delay_cnt_r <= delay_cnt_nxt;
         stamp_r     <= stamp_nxt;
         flags_r     <= flags_nxt;
         running_r   <= running_nxt;
         cleared_r   <= cleared_nxt;
         waiting_r   <= waiting_nxt;
         pend_r      <= pend_nxt;
         pend_byte_r <= pend_byte_nxt;
         addr_r      <= addr_nxt;
         count_r     <= count_nxt;
      end
   end

   // ****************************************************************
   // Register read path
   // ****************************************************************
   always_comb begin
      case (i_reg_addr)
         logger_mission_pkg::ADDR_THR_LO:     rdata_nxt = thr_lo_r;
         logger_mission_pkg::ADDR_THR_HI:     rdata_nxt = thr_hi_r;
         logger_mission_pkg::ADDR_SENSOR_CTL: rdata_nxt = sensor_r;
         logger_mission_pkg::ADDR_MISSION:    rdata_nxt = mission_r;
         logger_mission_pkg::ADDR_ALARMS:
            rdata_nxt = logger_mission_pkg::AF_FIXED_ONES | flags_r;
         logger_mission_pkg::ADDR_GENERAL: begin
            rdata_nxt = logger_mission_pkg::GS_FIXED_ONES |
               (i_backup_copy ? logger_mission_pkg::GS_BACKUP_MASK
                              : 8'h00);
            rdata_nxt[logger_mission_pkg::GS_RUNNING] = running_r;
            rdata_nxt[logger_mission_pkg::GS_CLEARED] = cleared_r;
            rdata_nxt[logger_mission_pkg::GS_WAITING] = waiting_r;
         end
         logger_mission_pkg::ADDR_DELAY_0: rdata_nxt = delay_r[7:0];
         logger_mission_pkg::ADDR_DELAY_1: rdata_nxt = delay_r[15:8];
         logger_mission_pkg::ADDR_DELAY_2: rdata_nxt = delay_r[23:16];
         logger_mission_pkg::ADDR_STAMP_0: rdata_nxt = stamp_r[7:0];
         logger_mission_pkg::ADDR_STAMP_1: rdata_nxt = stamp_r[15:8];
         logger_mission_pkg::ADDR_STAMP_2: rdata_nxt = stamp_r[23:16];
         logger_mission_pkg::ADDR_STAMP_3: rdata_nxt = stamp_r[31:24];
         default: rdata_nxt = 8'h00;
      endcase
   end

   // Registered read data
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_rdata <= 8'h00;
      end else if (i_ce) begin
         o_reg_rdata <= rdata_nxt;
      end
   end

   // Outputs
   assign o_log          = log_r;
   assign o_count_inc    = count_r;
   assign o_search_alarm = |(flags_r &
                             ~logger_mission_pkg::AF_FIXED_ONES);
   assign o_conv_8bit    = state_r ==
                           logger_mission_pkg::S_WAIT_ALARM;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // Every check below runs on the block clock and idles in reset
   default clocking cb_check @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   a_wipe_clears_flags: assert property (
      i_ce && i_memory_wipe_command && !running_r && !i_power_fail &&
      !i_conv.valid && !i_start_mission &&
      i_wipe_param == logger_mission_pkg::WIPE_PARAM
      |=> flags_r == 8'h00 && cleared_r)
      else $error("wipe left an alarm flag set");
   a_alarm_fixed_bits: assert property (
      i_ce && i_reg_addr == logger_mission_pkg::ADDR_ALARMS
      |=> o_reg_rdata[6:2] == 5'b11100)
      else $error("alarm status fixed bits wrong");
   a_high_flag_set: assert property (
      i_ce && alarm_armed && hi_hit
      |=> flags_r[logger_mission_pkg::AF_HIGH] && o_search_alarm)
      else $error("high alarm flag not raised");
   a_low_flag_held: assert property (
      flags_r[logger_mission_pkg::AF_LOW] && !i_memory_wipe_command
      |=> flags_r[logger_mission_pkg::AF_LOW])
      else $error("low alarm flag dropped");
   a_delay_locked: assert property (
      running_r && i_reg_wr |=> $stable(delay_r))
      else $error("start delay changed during mission");
   a_first_sample: assert property (
      i_ce && state_r == logger_mission_pkg::S_WAIT_ALARM && !start_ok &&
      !i_stop_mission && !i_conv.forced && (hi_hit || lo_hit) &&
      addr_r == logger_mission_pkg::LOG_BASE
      |=> o_log.we && !o_count_inc && !waiting_r &&
      state_r == logger_mission_pkg::S_LOGGING)
      else $error("trigger reading not logged as first sample");
   a_start_clears: assert property (
      i_ce && start_ok |=> running_r && !cleared_r &&
      addr_r == logger_mission_pkg::LOG_BASE)
      else $error("mission start did not update status");
   a_immediate_start: assert property (
      i_ce && start_ok && delay_r == 24'h000000 &&
      !mission_r[logger_mission_pkg::MC_ALARM_START]
      |=> state_r == logger_mission_pkg::S_LOGGING)
      else $error("immediate mission did not start logging");
   a_two_byte_order: assert property (
      o_log.we && pend_r && i_ce && state_r == logger_mission_pkg::S_LOGGING
      && !i_stop_mission && !start_ok
      |=> o_log.addr == $past(o_log.addr) + 24'h000001 &&
      !o_count_inc)
      else $error("two-byte reading not stored high then low");

endmodule // logger_mission_control_status

/* verification/host_bus_model.sv */
// Host side register bus master model for the mission control block
`timescale 1ns/1ns
module host_bus_model (
   input  wire logic        i_clk,
   input  wire logic [7:0]  i_rdata,
   output logic      [15:0] o_addr,
   output logic             o_wr,
   output logic      [7:0]  o_wdata
);
   // ****************************************************************
   // Bus idle state and access tasks
   // ****************************************************************
   initial begin
      o_addr = 16'h0000;
      o_wr = 1'b0;
      o_wdata = 8'h00;
   end

   // One-cycle write strobe, changed only on the falling edge
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(negedge i_clk);
      o_addr = a;
      o_wr = 1'b1;
      o_wdata = v;
      @(negedge i_clk);
      o_wr = 1'b0;
      o_wdata = ~v; // Stale data must not matter
   endtask

   // Read data is registered, so it is taken one edge later
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(negedge i_clk);
      o_addr = a;
      o_wr = 1'b0;
      @(negedge i_clk);
      v = i_rdata;
   endtask
endmodule // host_bus_model

/* verification/logger_mission_control_status_tb_top.sv */
// Self-checking bench for the logger mission control block
`timescale 1ns/1ns
module logger_mission_control_status_tb_top;
   logic                           clk, rst_n, tick, pf, wipe, stop, start;
   logic                           bkup, wr, cnt_inc, srch, c8;
   logic [7:0]                     rdata, wdata, wparam;
   logic [15:0]                    addr;
   logic [31:0]                    rtc;
   logger_mission_pkg::conv_s      conv;
   logger_mission_pkg::log_write_s lg;
   int                             n_mismatch = 0, cmp_count = 0, cyc = 0;

   logger_mission_control_status i_logger_mission_control_status (
      .i_clk(clk), .i_reset_n(rst_n), .i_ce(1'b1), .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_start_mission(start), .i_stop_mission(stop),
      .i_memory_wipe_command(wipe), .i_wipe_param(wparam),
      .i_power_fail(pf), .i_backup_copy(bkup), .i_minute_tick(tick),
      .i_rtc_seconds(rtc), .i_conv(conv), .o_log(lg),
      .o_count_inc(cnt_inc), .o_search_alarm(srch), .o_conv_8bit(c8));
   host_bus_model i_host_bus_model (.i_clk(clk), .i_rdata(rdata),
      .o_addr(addr), .o_wr(wr), .o_wdata(wdata));

   // ****************************************************************
   // Clock, timeout and helper tasks
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rc(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] v;
      i_host_bus_model.rd(a, v);
      chk({26'h0, v}, {26'h0, e});
   endtask

   // Command pulses {tick, power fail, wipe, stop, start}
   task automatic cmd(input logic [4:0] k);
      @(negedge clk);
      {tick, pf, wipe, stop, start} = k;
      @(negedge clk);
      {tick, pf, wipe, stop, start} = 5'h00;
   endtask

   // One conversion; returns where the first log byte is visible
   task automatic cv(input logic [15:0] v, input logic f = 1'b0);
      @(negedge clk);
      conv = '{data: v, valid: 1'b1, forced: f};
      @(negedge clk);
      conv.valid = 1'b0;
   endtask

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      {rst_n, tick, pf, wipe, stop, start, bkup} = 7'h00;
      wparam = 8'h02;
      rtc = 32'h12345678;
      conv = '{data: 16'h0000, valid: 1'b0, forced: 1'b0};
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      rc(logger_mission_pkg::ADDR_ALARMS, 8'hf0);
      rc(logger_mission_pkg::ADDR_MISSION, 8'hd0);
      $display("test reset done");
      cmd(5'h04);
      rc(logger_mission_pkg::ADDR_GENERAL, 8'hc0);
      wparam = 8'h01;
      cmd(5'h04);
      rc(logger_mission_pkg::ADDR_ALARMS, 8'h70);
      rc(logger_mission_pkg::ADDR_GENERAL, 8'hc8);
      $display("test wipe done");
      i_host_bus_model.wr(logger_mission_pkg::ADDR_THR_HI, 8'h80);
      i_host_bus_model.wr(logger_mission_pkg::ADDR_THR_LO, 8'h10);
      i_host_bus_model.wr(logger_mission_pkg::ADDR_SENSOR_CTL, 8'h03);
      i_host_bus_model.wr(logger_mission_pkg::ADDR_DELAY_0, 8'h02);
      i_host_bus_model.wr(logger_mission_pkg::ADDR_MISSION, 8'h25);
      rc(logger_mission_pkg::ADDR_MISSION, 8'hf5);
      cmd(5'h01);
      rc(logger_mission_pkg::ADDR_GENERAL, 8'hd2);
      rc(logger_mission_pkg::ADDR_STAMP_0, 8'h78);
      i_host_bus_model.wr(logger_mission_pkg::ADDR_DELAY_0, 8'h05);
      rc(logger_mission_pkg::ADDR_DELAY_0, 8'h02);
      $display("test start done");
      cv(16'h9000);
      chk({33'h0, lg.we}, 34'h0);
      rc(logger_mission_pkg::ADDR_ALARMS, 8'h70);
      cmd(5'h10);
      cmd(5'h10);
      chk({33'h0, c8}, 34'h1);
      cv(16'h9034);
      chk({cnt_inc, lg}, {2'b01, 24'h001000, 8'h90});
      @(negedge clk);
      chk({cnt_inc, lg}, {2'b01, 24'h001001, 8'h34});
      rc(logger_mission_pkg::ADDR_ALARMS, 8'h72);
      rc(logger_mission_pkg::ADDR_GENERAL, 8'hc2);
      chk({33'h0, srch}, 34'h1);
      chk({33'h0, c8}, 34'h0);
      cv(16'h5511);
      chk({cnt_inc, lg}, {2'b11, 24'h001002, 8'h55});
      $display("test logging done");
      cmd(5'h02);
      rc(logger_mission_pkg::ADDR_GENERAL, 8'hc0);
      bkup = 1'b1;
      rc(logger_mission_pkg::ADDR_GENERAL, 8'he5);
      bkup = 1'b0;
      cv(16'h0500, 1'b1);
      cmd(5'h08);
      rc(logger_mission_pkg::ADDR_ALARMS, 8'hf3);
      $display("test stop done");
      tally_and_finish();
   end
endmodule // logger_mission_control_status_tb_top
